// *** logic/pcs_top.sv ***
// program counter, latches, fetch/execute pipeline and apb registers
// assumes program memory answers within the phase that follows
// prog_addr, and the core holds core_op through phase four
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/100ps
module pcs_top (
	input  wire logic                       clk_sys,
	input  wire logic                       resetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [pcs_pkg::PADDR_W-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire pcs_pkg::pcs_core_op_t      core_op,
	input  wire logic [pcs_pkg::PC_W-1:0]   core_target,
	input  wire logic [pcs_pkg::INSN_W-1:0] prog_data,
	output logic      [pcs_pkg::PC_W-1:0]   prog_addr,
	output logic      [pcs_pkg::INSN_W-1:0] instruction_register,
	output logic                            ir_valid,
	output logic                            phase_one,
	output logic                            phase_two,
	output logic                            phase_three,
	output logic                            phase_four,
	output logic                            stack_full,
	output logic                            stack_overflow,
	output logic                            stack_underflow,
	output logic                            ext_insn_enable
);
	import pcs_pkg::*;

	// =====================================================
	// state
	typedef struct packed {
		logic [PC_W-1:0]          pc;
		logic [7:0]               pc_high_latch;
		logic [UPPER_LATCH_W-1:0] pc_upper_latch;
		logic [INSN_W-1:0]        fetch_word;
		logic [INSN_W-1:0]        ir;
		logic                     ir_valid;
		logic                     flush;
		logic [PC_W-1:0]          prog_addr;
		logic                     ext_en;
		logic                     pready;
		logic [31:0]              prdata;
		logic                     pslverr;
	} pcs_seq_state_t;

	pcs_seq_state_t r_reg;
	pcs_seq_state_t r_next;
	logic [3:0]     phase;
	logic           apb_setup;
	logic           apb_done;
	logic           wr_done;
	logic           rd_done;
	logic           pcl_write;
	logic           pcl_read;
	logic           exec_op;

	pcs_stack_if stk ();

	// =====================================================
	// submodules
	pcs_phase_gen u_phase (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.phase   (phase)
	);

	pcs_return_stack #(
		.DEPTH (STACK_LVLS)
	) u_stack (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.stk     (stk)
	);

	// =====================================================
	// address decode: is_mapped for the error check, read_mux decodes on its own
	function automatic logic is_mapped(input logic [PADDR_W-1:0] a);
		case (a)
			OFS_PC_LOW, OFS_PC_HIGH_L, OFS_PC_UPPER_L, OFS_STACK_PTR,
			OFS_TOS_LOW, OFS_TOS_HIGH, OFS_TOS_UPPER, OFS_CONTROL:
				is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	function automatic logic [31:0] read_mux(input pcs_seq_state_t s,
		input logic [PADDR_W-1:0] a, input logic [PC_W-1:0] top_of_stack,
		input logic [SP_W-1:0] sp, input logic [2:0] flg);
		read_mux = '0;
		case (a)
			OFS_PC_LOW:     read_mux[7:0] = s.pc[7:0];
			OFS_PC_HIGH_L:  read_mux[7:0] = s.pc_high_latch;
			OFS_PC_UPPER_L: read_mux[UPPER_LATCH_W-1:0] = s.pc_upper_latch;
			OFS_STACK_PTR:  read_mux[7:0] = {flg, sp};
			OFS_TOS_LOW:    read_mux[7:0] = top_of_stack[7:0];
			OFS_TOS_HIGH:   read_mux[7:0] = top_of_stack[15:8];
			OFS_TOS_UPPER:  read_mux[4:0] = top_of_stack[20:16];
			OFS_CONTROL:    read_mux[CTL_EXT_BIT] = s.ext_en;
			default:        read_mux = '0;
		endcase
	endfunction : read_mux

	// =====================================================
	// bus handshake terms
	// pready rises in the access phase, so every transfer takes two
	// cycles and side effects land on the completing edge only
	assign apb_setup = psel && !penable;
	assign apb_done  = psel && penable && r_reg.pready;
	assign wr_done   = apb_done && pwrite && !r_reg.pslverr;
	assign rd_done   = apb_done && !pwrite && !r_reg.pslverr;
	assign pcl_write = wr_done && paddr == OFS_PC_LOW;
	assign pcl_read  = rd_done && paddr == OFS_PC_LOW;
	// a flushed slot executes as a no-operation
	assign exec_op   = phase[3] && r_reg.ir_valid;

	// =====================================================
	// next state
	always_comb begin
		r_next = r_reg;
		stk.push        = 1'b0;
		stk.pop         = 1'b0;
		stk.push_value  = r_reg.prog_addr;
		stk.top_byte_wr = 3'b000;
		stk.wr_data     = pwdata[7:0];
		stk.ptr_wr      = 1'b0;

		// bus answer is prepared in the setup cycle
		r_next.pready = apb_setup;
		if (apb_setup) begin
			r_next.pslverr = !is_mapped(paddr);
			r_next.prdata  = pwrite ? '0 : read_mux(r_reg, paddr,
				stk.top_value, stk.ptr,
				{stk.overflow, stk.underflow, stk.full});
		end else if (apb_done) begin
			r_next.pslverr = 1'b0;
		end

		// fetch cycle: address goes out and pc steps in phase one
		if (phase[0]) begin
			r_next.prog_addr = r_reg.pc;
			r_next.pc        = r_reg.pc + PC_STEP;
			r_next.ir        = r_reg.fetch_word;
			r_next.ir_valid  = !r_reg.flush;
			r_next.flush     = 1'b0;
		end
		if (phase[3]) begin
			r_next.fetch_word = prog_data;
		end

		// software side
		if (pcl_read) begin
			r_next.pc_high_latch  = r_reg.pc[15:8];
			r_next.pc_upper_latch = r_reg.pc[20:16];
		end
		if (wr_done) begin
			case (paddr)
				OFS_PC_HIGH_L:  r_next.pc_high_latch = pwdata[7:0];
				OFS_PC_UPPER_L: r_next.pc_upper_latch =
					pwdata[UPPER_LATCH_W-1:0];
				OFS_STACK_PTR:  stk.ptr_wr = 1'b1;
				OFS_TOS_LOW:    stk.top_byte_wr = 3'b001;
				OFS_TOS_HIGH:   stk.top_byte_wr = 3'b010;
				OFS_TOS_UPPER:  stk.top_byte_wr = 3'b100;
				OFS_CONTROL:    r_next.ext_en = pwdata[CTL_EXT_BIT];
				default:        r_next.ext_en = r_reg.ext_en;
			endcase
		end
		if (pcl_write) begin
			// latches land in the upper bits; bit zero stays clear
			r_next.pc = {r_reg.pc_upper_latch, r_reg.pc_high_latch,
				pwdata[7:1], 1'b0};
			r_next.flush = 1'b1;
		end

		// execute path: acted on at the end of phase four
		if (exec_op) begin
			case (core_op)
				OP_CALL, OP_INT_ACK: begin
					stk.push     = 1'b1;
					r_next.pc    = {core_target[PC_W-1:1], 1'b0};
					r_next.flush = 1'b1;
				end
				OP_JUMP: begin
					r_next.pc    = {core_target[PC_W-1:1], 1'b0};
					r_next.flush = 1'b1;
				end
				OP_RETURN: begin
					stk.pop      = 1'b1;
					r_next.pc    = {stk.top_value[PC_W-1:1], 1'b0};
					r_next.flush = 1'b1;
				end
				OP_UNLINK: begin
					if (r_reg.ext_en) begin
						stk.pop      = 1'b1;
						r_next.pc    = {stk.top_value[PC_W-1:1], 1'b0};
						r_next.flush = 1'b1;
					end
				end
				default: r_next.flush = r_next.flush;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	// =====================================================
	// outputs
	assign prdata               = r_reg.prdata;
	assign pready               = r_reg.pready;
	assign pslverr              = r_reg.pslverr;
	assign prog_addr            = r_reg.prog_addr;
	assign instruction_register = r_reg.ir;
	assign ir_valid             = r_reg.ir_valid;
	assign phase_one            = phase[0];
	assign phase_two            = phase[1];
	assign phase_three          = phase[2];
	assign phase_four           = phase[3];
	assign stack_full           = stk.full;
	assign stack_overflow       = stk.overflow;
	assign stack_underflow      = stk.underflow;
	assign ext_insn_enable      = r_reg.ext_en;

	// =====================================================
	// checks
	sequence s_redirect;
		exec_op && (core_op == OP_JUMP || core_op == OP_CALL ||
			core_op == OP_RETURN || core_op == OP_INT_ACK);
	endsequence

	sequence s_flush_slot;
		##2 !ir_valid ##4 1'b1;
	endsequence

	AST_PC_WORD_ALIGNED: assert property (@(posedge clk_sys)
		disable iff (!resetn) r_reg.pc[0] == 1'b0 && prog_addr[0] == 1'b0)
		else $error("pc lost word alignment");

	AST_FETCH_STEP: assert property (@(posedge clk_sys)
		disable iff (!resetn) phase[0] && !pcl_write |=>
		r_reg.pc == $past(r_reg.pc) + PC_STEP &&
		prog_addr == $past(r_reg.pc))
		else $error("fetch did not step pc by two in phase one");

	AST_PCL_WRITE_LOADS: assert property (@(posedge clk_sys)
		disable iff (!resetn) pcl_write && !exec_op |=>
		r_reg.pc[20:8] == {$past(r_reg.pc_upper_latch),
			$past(r_reg.pc_high_latch)})
		else $error("low byte write did not load latches into pc");

	AST_PCL_READ_COPIES: assert property (@(posedge clk_sys)
		disable iff (!resetn) pcl_read |=>
		r_reg.pc_high_latch == $past(r_reg.pc[15:8]) &&
		r_reg.pc_upper_latch == $past(r_reg.pc[20:16]))
		else $error("low byte read did not refresh latches");

	AST_JUMP_DIRECT: assert property (@(posedge clk_sys)
		disable iff (!resetn) exec_op && core_op == OP_JUMP |=>
		r_reg.pc == {$past(core_target[PC_W-1:1]), 1'b0})
		else $error("jump did not load target directly");

	AST_CALL_KEEPS_LATCH: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		exec_op && (core_op == OP_CALL || core_op == OP_RETURN) &&
		!wr_done && !pcl_read |=>
		$stable(r_reg.pc_high_latch) && $stable(r_reg.pc_upper_latch))
		else $error("call or return touched the latches");

	AST_CALL_PUSHES: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		exec_op && core_op == OP_CALL && !stk.full && !stk.ptr_wr |=>
		stk.top_value == $past(r_reg.prog_addr))
		else $error("call did not push return address");

	AST_REDIRECT_FLUSH: assert property (@(posedge clk_sys)
		disable iff (!resetn) s_redirect |-> s_flush_slot)
		else $error("slot after a pc change was not flushed");

	AST_IR_PHASE_ONE: assert property (@(posedge clk_sys)
		disable iff (!resetn) !phase[0] |=> $stable(r_reg.ir))
		else $error("instruction register moved outside phase one");

	AST_APB_ANSWER: assert property (@(posedge clk_sys)
		disable iff (!resetn) apb_setup |=> pready ##1 !pready)
		else $error("apb answer not in the access cycle");

endmodule : pcs_top

// *** include/pcs_pkg.sv ***
// constants, types and encodings for the program sequencing block
// assumes a single 100 MHz clock, APB register access, one core
//
// Notes on behaviour
// - pc is 21 bits in three bytes
// - low byte direct; high byte via latch
// - upper bits only via upper latch
// - low byte write loads both latches in
// - low byte read copies pc into latches
// - pc bit zero fixed; fetch adds two
// - calls, jumps, branches load pc directly
// - push on call or interrupt acknowledge
// - pop on returns and enabled unlinks
// - calls and returns keep latches unchanged
// - 31 entries of 21 bits, 5-bit pointer
// - push: increment pointer, then store pc
// - pop: load pc, then decrement pointer
// - reset clears pointer; zero means empty
// - flags show full, overflow and underflow
// - three top-of-stack byte registers
// - clock divided into four phases
// - pc steps in phase one, word latched four
// - ir loads phase one, decodes two to four
// - pc change costs two cycles, flush
package pcs_pkg;

	localparam int PC_W       = 21;
	localparam int SP_W       = 5;
	localparam int STACK_LVLS = 31;
	localparam int INSN_W     = 16;
	localparam int PADDR_W    = 8;

	// =====================================================
	// register byte offsets
	localparam logic [PADDR_W-1:0] OFS_PC_LOW     = 8'h00;
	localparam logic [PADDR_W-1:0] OFS_PC_HIGH_L  = 8'h04;
	localparam logic [PADDR_W-1:0] OFS_PC_UPPER_L = 8'h08;
	localparam logic [PADDR_W-1:0] OFS_STACK_PTR  = 8'h0c;
	localparam logic [PADDR_W-1:0] OFS_TOS_LOW    = 8'h10;
	localparam logic [PADDR_W-1:0] OFS_TOS_HIGH   = 8'h14;
	localparam logic [PADDR_W-1:0] OFS_TOS_UPPER  = 8'h18;
	localparam logic [PADDR_W-1:0] OFS_CONTROL    = 8'h1c;

	// =====================================================
	// field positions
	localparam int SPR_FULL_BIT  = 5;
	localparam int SPR_UNF_BIT   = 6;
	localparam int SPR_OVF_BIT   = 7;
	localparam int CTL_EXT_BIT   = 0;
	localparam int UPPER_LATCH_W = 5;

	// =====================================================
	// reset values and steps
	localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
	localparam logic [PC_W-1:0] PC_STEP  = 21'h000002;
	localparam logic [3:0]      PHASE_RESET = 4'h8;

	typedef enum logic [2:0] {
		OP_NONE    = 3'b000,
		OP_CALL    = 3'b001,
		OP_JUMP    = 3'b010,
		OP_RETURN  = 3'b011,
		OP_UNLINK  = 3'b100,
		OP_INT_ACK = 3'b101
	} pcs_core_op_t;

endpackage : pcs_pkg

// *** include/pcs_stack_if.sv ***
// request and status signals between sequencer and return stack
// assumes both ends on clk_sys
`timescale 1ns/100ps
interface pcs_stack_if;
	import pcs_pkg::*;
	logic                    push;
	logic                    pop;
	logic [PC_W-1:0]         push_value;
	logic [2:0]              top_byte_wr;
	logic [7:0]              wr_data;
	logic                    ptr_wr;
	logic [SP_W-1:0]         ptr;
	logic [PC_W-1:0]         top_value;
	logic                    full;
	logic                    overflow;
	logic                    underflow;

	modport user  (output push, pop, push_value, top_byte_wr, wr_data,
		ptr_wr, input ptr, top_value, full, overflow, underflow);
	modport stack (input push, pop, push_value, top_byte_wr, wr_data,
		ptr_wr, output ptr, top_value, full, overflow, underflow);
endinterface : pcs_stack_if

// *** logic/pcs_phase_gen.sv ***
// four-phase instruction cycle generator, one-hot
// assumes clk_sys is the core input clock
`timescale 1ns/100ps
module pcs_phase_gen (
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	output logic [3:0]      phase
);
	import pcs_pkg::*;

	typedef struct packed {
		logic [3:0] phase;
	} pcs_phase_state_t;

	pcs_phase_state_t r_reg;
	pcs_phase_state_t r_next;

	// reset parks in phase four so the first edge opens phase one
	always_comb begin
		r_next = r_reg;
		r_next.phase = {r_reg.phase[2:0], r_reg.phase[3]};
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			r_reg <= '{phase: PHASE_RESET};
		end else begin
			r_reg <= r_next;
		end
	end

	assign phase = r_reg.phase;

	AST_PHASE_ONEHOT: assert property (@(posedge clk_sys) disable iff (!resetn)
		$onehot(phase))
		else $error("phase ring not one-hot");

	AST_PHASE_ORDER: assert property (@(posedge clk_sys) disable iff (!resetn)
		phase[0] |=> phase[1])
		else $error("phase ring out of order");

endmodule : pcs_phase_gen

// *** logic/pcs_return_stack.sv ***
// return address stack storage, pointer and status flags
// assumes one request at a time; push and pop never together
`timescale 1ns/100ps
module pcs_return_stack #(
	parameter int DEPTH = pcs_pkg::STACK_LVLS
) (
	input  wire logic  clk_sys,
	input  wire logic  resetn,
	pcs_stack_if.stack stk
);
	import pcs_pkg::*;

	if (DEPTH != STACK_LVLS) begin : g_bad_depth
		$error("stack depth must equal the 5-bit pointer range");
	end

	typedef struct packed {
		logic [DEPTH:1][PC_W-1:0] mem;
		logic [SP_W-1:0]          ptr;
		logic                     ovf;
		logic                     unf;
	} pcs_stack_state_t;

	pcs_stack_state_t r_reg;
	pcs_stack_state_t r_next;
	logic             full;

	assign full = (r_reg.ptr == SP_W'(DEPTH));

	always_comb begin
		r_next = r_reg;
		// software clears a flag by writing zero; a new event wins
		if (stk.ptr_wr) begin
			r_next.ptr = stk.wr_data[SP_W-1:0];
			r_next.ovf = r_reg.ovf & stk.wr_data[SPR_OVF_BIT];
			r_next.unf = r_reg.unf & stk.wr_data[SPR_UNF_BIT];
		end
		for (int b = 0; b < 3; b++) begin
			if (stk.top_byte_wr[b] && r_reg.ptr != '0) begin
				r_next.mem[r_reg.ptr][b*8 +: 8] = stk.wr_data;
			end
		end
		if (stk.push) begin
			if (full) begin
				r_next.ovf = 1'b1;
			end else begin
				r_next.ptr = r_reg.ptr + 1'b1;
				r_next.mem[r_reg.ptr + 1'b1] = stk.push_value;
			end
		end else if (stk.pop) begin
			if (r_reg.ptr == '0) begin
				r_next.unf = 1'b1;
			end else begin
				r_next.ptr = r_reg.ptr - 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	// pointer zero has no entry behind it and reads as zero
	assign stk.top_value = (r_reg.ptr == '0) ? '0 : r_reg.mem[r_reg.ptr];
	assign stk.ptr       = r_reg.ptr;
	assign stk.full      = full;
	assign stk.overflow  = r_reg.ovf;
	assign stk.underflow = r_reg.unf;

	AST_PUSH_STEP: assert property (@(posedge clk_sys) disable iff (!resetn)
		stk.push && !full && !stk.ptr_wr |=>
		stk.ptr == $past(stk.ptr) + 1'b1 &&
		stk.top_value == $past(stk.push_value))
		else $error("push did not step pointer and store value");

	AST_POP_STEP: assert property (@(posedge clk_sys) disable iff (!resetn)
		stk.pop && stk.ptr != '0 && !stk.ptr_wr |=>
		stk.ptr == $past(stk.ptr) - 1'b1)
		else $error("pop did not step pointer down");

	AST_OVERFLOW_KEEP: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		stk.push && full && !stk.ptr_wr && stk.top_byte_wr == '0 |=>
		stk.overflow && $stable(r_reg.mem) && stk.ptr == 5'h1f)
		else $error("overflow push altered stack or missed flag");

	AST_UNDERFLOW: assert property (@(posedge clk_sys) disable iff (!resetn)
		stk.pop && stk.ptr == '0 |=>
		stk.underflow && stk.top_value == '0)
		else $error("underflow not flagged");

endmodule : pcs_return_stack

// *** tb/pcs_prog_mem.sv ***
// program memory model for the sequencing block's fetch port
// assumes prog_addr is held for the whole instruction cycle
`timescale 1ns/100ps
module pcs_prog_mem
	import pcs_pkg::*;
(
	input  wire logic [PC_W-1:0]   prog_addr,
	output logic      [INSN_W-1:0] prog_data
);
	// =====================================================
	// contents
	// every word differs from its neighbours, so a stale or
	// misaligned fetch cannot pass for the right one
	assign prog_data = prog_addr[16:1] ^ 16'ha5c3;
endmodule : pcs_prog_mem

// *** tb/pc_stack_fetch_pipeline_bench.sv ***
// self-checking bench for pcs_top with a program memory model
// assumes apb reads answer in one access cycle, core ops in phase four
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module pc_stack_fetch_pipeline_bench;
	import pcs_pkg::*;
	logic                clk_sys, resetn, psel, penable, pwrite;
	logic                pready, pslverr, ir_valid, ext_insn_enable;
	logic                phase_one, phase_two, phase_three, phase_four;
	logic                stack_full, stack_overflow, stack_underflow;
	logic [PADDR_W-1:0]  paddr;
	logic [31:0]         pwdata, prdata;
	pcs_core_op_t        core_op;
	logic [PC_W-1:0]     core_target, prog_addr, ret, r, t, tg;
	logic [INSN_W-1:0]   prog_data, instruction_register;
	logic [7:0]          hl, lo;
	logic [4:0]          ul;
	logic [3:0]          ph_exp;
	logic [32:0]         exp_q[$], msk_q[$];
	int                  miscompares, n_tests;

	pcs_top pcs_top_inst (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.core_op(core_op), .core_target(core_target),
		.prog_data(prog_data), .prog_addr(prog_addr),
		.instruction_register(instruction_register), .ir_valid(ir_valid),
		.phase_one(phase_one), .phase_two(phase_two),
		.phase_three(phase_three), .phase_four(phase_four),
		.stack_full(stack_full), .stack_overflow(stack_overflow),
		.stack_underflow(stack_underflow),
		.ext_insn_enable(ext_insn_enable));
	pcs_prog_mem pcs_prog_mem_inst (.prog_addr(prog_addr),
		.prog_data(prog_data));

	function automatic logic [INSN_W-1:0] word_at(input logic [PC_W-1:0] a);
		return a[16:1] ^ 16'ha5c3;
	endfunction : word_at

	// =====================================================
	// clock, phase tracker and read monitor
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) ph_exp <= 4'h1;
		else ph_exp <= {ph_exp[0], ph_exp[3:1]};
	end
	always @(negedge clk_sys) begin
		if (resetn) `CHK({phase_one, phase_two, phase_three, phase_four}, ph_exp)
	end
	always @(posedge clk_sys) begin
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
			`CHK({pslverr, prdata} & msk_q[0], exp_q[0] & msk_q[0])
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end

	// =====================================================
	// bus and core tasks
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [32:0] e,
		input logic [32:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		apb(1'b0, a, 32'h0);
	endtask : rd
	// fl set: the op must redirect fetch to a and flush one slot
	task automatic core_do(input pcs_core_op_t op, input logic [PC_W-1:0] a,
		input logic fl);
		int n;
		logic [PC_W-1:0] e;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (!(phase_three === 1'b1 && ir_valid === 1'b1) && n < 40);
		ret = prog_addr;
		e = fl ? a : ret + PC_STEP;
		core_op     <= op;
		core_target <= a;
		@(posedge clk_sys);
		core_op <= OP_NONE;
		@(posedge clk_sys);
		#1;
		`CHK(ir_valid, !fl)
		`CHK(prog_addr, e)
		repeat (4) @(posedge clk_sys);
		#1;
		`CHK(instruction_register, word_at(e))
		`CHK(ir_valid, 1'b1)
		`CHK(prog_addr, e + PC_STEP)
		@(posedge clk_sys);
	endtask : core_do

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	initial begin
		#100000;
		miscompares++;
		report_and_stop();
	end

	// =====================================================
	// main sequence; no interrupt ack overlaps a stack access
	initial begin
		int n;
		{resetn, psel, penable, pwrite, paddr, pwdata} = '0;
		core_op = OP_NONE;
		core_target = '0;
		void'($urandom(32'he06542ac));
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(OFS_STACK_PTR, 33'h0, 33'h0ff);
		rd(OFS_PC_HIGH_L, 33'h0, 33'h1ffffffff);
		rd(OFS_PC_UPPER_L, 33'h0, 33'h1ffffffff);
		rd(OFS_TOS_LOW, 33'h0, 33'h1ffffffff);
		rd(OFS_CONTROL, 33'h0, 33'h1ffffffff);
		rd(8'h40, 33'h100000000, 33'h1ffffffff);
		$display("test reset_values done");

		hl = $urandom;
		ul = $urandom;
		lo = $urandom & 8'h3f;
		wr(OFS_PC_HIGH_L, {24'h0, hl});
		wr(OFS_PC_UPPER_L, {27'h0, ul});
		rd(OFS_PC_UPPER_L, {28'h0, ul}, 33'h1ffffffff);
		wr(OFS_PC_LOW, {24'h0, lo | 8'h01});
		t = {ul, hl, lo[7:1], 1'b0};
		n = 0;
		while (prog_addr !== t && n < 12) begin
			@(posedge clk_sys);
			n++;
		end
		`CHK(prog_addr, t)
		wr(OFS_PC_HIGH_L, {24'h0, ~hl});
		wr(OFS_PC_UPPER_L, {27'h0, ~ul});
		rd(OFS_PC_LOW, 33'h0, 33'h100000001);
		rd(OFS_PC_HIGH_L, {25'h0, hl}, 33'h1ffffffff);
		rd(OFS_PC_UPPER_L, {28'h0, ul}, 33'h1ffffffff);
		$display("test pc_latches done");

		tg = $urandom & 21'h1ffffe;
		core_do(OP_JUMP, tg, 1'b1);
		core_do(OP_CALL, tg ^ 21'h100000, 1'b1);
		r = ret;
		rd(OFS_STACK_PTR, 33'h1, 33'h0ff);
		rd(OFS_TOS_LOW, {25'h0, r[7:0]}, 33'h1ffffffff);
		rd(OFS_TOS_HIGH, {25'h0, r[15:8]}, 33'h1ffffffff);
		rd(OFS_TOS_UPPER, {28'h0, r[20:16]}, 33'h1ffffffff);
		core_do(OP_RETURN, r, 1'b1);
		rd(OFS_STACK_PTR, 33'h0, 33'h0ff);
		rd(OFS_PC_HIGH_L, {25'h0, hl}, 33'h1ffffffff);
		core_do(OP_CALL, tg, 1'b1);
		r = ret;
		core_do(OP_UNLINK, 21'h0, 1'b0);
		wr(OFS_CONTROL, 32'h1);
		`CHK(ext_insn_enable, 1'b1)
		core_do(OP_UNLINK, r, 1'b1);
		$display("test call_return done");

		core_do(OP_INT_ACK, tg, 1'b1);
		rd(OFS_STACK_PTR, 33'h1, 33'h0ff);
		t = $urandom & 21'h1ffffe;
		wr(OFS_TOS_LOW, {24'h0, t[7:0]});
		wr(OFS_TOS_HIGH, {24'h0, t[15:8]});
		wr(OFS_TOS_UPPER, {27'h0, t[20:16]});
		core_do(OP_RETURN, t, 1'b1);
		$display("test tos_write done");

		for (int i = 0; i < STACK_LVLS; i++) core_do(OP_CALL, tg, 1'b1);
		r = ret;
		rd(OFS_STACK_PTR, 33'h3f, 33'h0ff);
		core_do(OP_CALL, tg ^ 21'h000100, 1'b1);
		rd(OFS_STACK_PTR, 33'hbf, 33'h0ff);
		`CHK({stack_full, stack_overflow, stack_underflow}, 3'b110)
		rd(OFS_TOS_LOW, {25'h0, r[7:0]}, 33'h1ffffffff);
		wr(OFS_STACK_PTR, 32'h0);
		rd(OFS_STACK_PTR, 33'h0, 33'h0ff);
		core_do(OP_RETURN, 21'h0, 1'b1);
		rd(OFS_STACK_PTR, 33'h40, 33'h0ff);
		`CHK({stack_full, stack_overflow, stack_underflow}, 3'b001)
		$display("test stack_limits done");
		report_and_stop();
	end
endmodule : pc_stack_fetch_pipeline_bench
